// ===== hw/udc_regs.sv
// usb device control and status registers behind an axi4-lite slave
// assumes event pulses from the usb engine are one cycle, synchronous to aclk
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module udc_regs
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address and data
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // usb engine events (one-cycle pulses), their qualifiers and the bus idle level
  input wire logic ev_bus_reset_end,
  input wire logic ev_sof,
  input wire logic [10:0] sof_frame_number,
  input wire logic sof_crc_bad,
  input wire logic ev_end_of_resume,
  input wire logic ev_line_wake,
  input wire logic ev_setup,
  input wire logic [2:0] setup_ep,
  input wire logic bus_idle,
  // usb engine controls
  output logic pullup_dp,
  output logic pullup_dm,
  output logic resume_drive,
  output logic cpu_reset,
  output logic [6:0] dev_address,
  output logic address_live,
  output logic [6:0] ep_enable,
  output logic [6:0] ep_fifo_reset,
  output logic [6:0] ep_stall,
  output logic [6:0] ep_toggle_clear,
  output logic usb_irq
);
  import udc_pkg::*;
  // all state of the block except the suspend timer's count and hit flop
  typedef struct packed
  {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] usbcon;
    logic [3:0] ctrl;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] addr;
    logic [10:0] frame_number;
    logic fcrc;
    logic [2:0] epsel;
    logic [6:0] fifo_reset;
    logic [6:0] endpoint_enable;
    logic [6:0] stall;
    logic [6:0] togclr;
    logic [15:0] rsm_cnt;
    logic resume;
    logic cpurst;
    logic addr_live;
    logic irq;
    logic pu_dp; // full-speed pull-up pin
    logic pu_dm; // low-speed pull-up pin
  } udc_state_t;
  udc_state_t state_reg;
  udc_state_t state_next;
  logic susp_hit;
  logic [7:0] wbyte;
  logic wr_go;
  // bus idle timer for suspend detection
  udc_timer #(
    .LIMIT(UDC_SUSP_CYC)
  ) u_susp (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(bus_idle),
    .hit(susp_hit)
  );
  // read mux, reserved bits zero
  function automatic logic [7:0] rd_mux(input udc_state_t s, input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      UDC_OFF_CTRL: v = {4'h0, s.ctrl};
      UDC_OFF_FLAGS: v = s.flags & UDC_FLAG_MASK;
      UDC_OFF_ENABLES: v = s.enables & UDC_FLAG_MASK;
      UDC_OFF_ADDR: v = s.addr;
      UDC_OFF_FRAME_NUMBER_HI: v = {5'h00, s.frame_number[10:8]};
      UDC_OFF_FRAME_NUMBER_LO: v = s.frame_number[7:0];
      UDC_OFF_FERR: v = {3'h0, s.fcrc, 4'h0};
      UDC_OFF_EPSEL: v = {5'h00, s.epsel};
      UDC_OFF_FIFO_RESET: v = {1'b0, s.fifo_reset};
      UDC_OFF_EPCTRL: v = {2'h0, s.stall[s.epsel], 4'h0, s.endpoint_enable[s.epsel]};
      UDC_OFF_USBCON: v = {6'h00, s.usbcon};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux
  // address decode check
  function automatic logic mapped(input logic [5:0] a);
    return (a <= UDC_OFF_USBCON) && (a[1:0] == 2'h0);
  endfunction : mapped
  assign wr_go = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
  assign wbyte = state_reg.w_strb[0] ? state_reg.w_data[7:0] : 8'h00;
  // next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.togclr = 7'h00;
    state_next.cpurst = 1'b0;
    // capture write address and data in either order
    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_have = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    state_next.awready = !state_next.aw_have;
    state_next.wready = !state_next.w_have;
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end
    // hardware events set flags; the set wins over a clearing write
    // register writes, low byte lane only
    if (wr_go && state_reg.w_strb[0])
    begin
      case (state_reg.aw_addr)
        UDC_OFF_CTRL:
        begin
          state_next.ctrl[UDC_B_DETACH] = wbyte[UDC_B_DETACH];
          state_next.ctrl[UDC_B_LSPEED] = wbyte[UDC_B_LSPEED];
          state_next.ctrl[UDC_B_CPURST] = wbyte[UDC_B_CPURST];
          // only a set is accepted, and only in suspend
          if (wbyte[UDC_B_RMWAKE] && state_reg.flags[UDC_B_SUSP])
          begin
            state_next.ctrl[UDC_B_RMWAKE] = 1'b1;
          end
        end
        UDC_OFF_FLAGS: state_next.flags = state_reg.flags & wbyte & UDC_FLAG_MASK;
        UDC_OFF_ENABLES: state_next.enables = wbyte & UDC_FLAG_MASK;
        UDC_OFF_ADDR:
        begin
          state_next.addr[6:0] = wbyte[6:0];
          if (wbyte[UDC_B_ADDR_ACT])
          begin
            state_next.addr[UDC_B_ADDR_ACT] = 1'b1;
          end
        end
        UDC_OFF_EPSEL: state_next.epsel = wbyte[2:0];
        UDC_OFF_FIFO_RESET: state_next.fifo_reset = wbyte[6:0];
        UDC_OFF_EPCTRL:
        begin
          if (state_reg.epsel != UDC_EP_FORBIDDEN)
          begin
            state_next.endpoint_enable[state_reg.epsel] = wbyte[UDC_B_ENDPOINT_ENABLE];
            if (wbyte[UDC_B_STREQ])
            begin
              state_next.stall[state_reg.epsel] = 1'b1;
            end
            if (wbyte[UDC_B_STCLR])
            begin
              state_next.stall[state_reg.epsel] = 1'b0;
            end
            state_next.togclr[state_reg.epsel] = wbyte[UDC_B_TOGRST];
          end
        end
        UDC_OFF_USBCON: state_next.usbcon = wbyte[1:0];
        default: state_next.usbcon = state_next.usbcon;
      endcase
    end
    if (wr_go)
    begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
      state_next.bvalid = 1'b1;
      state_next.bresp = mapped(state_reg.aw_addr) ? UDC_RESP_OKAY : UDC_RESP_SLVERR;
    end
    // disabled controller drops the cpu-reset option
    if (!state_reg.usbcon[UDC_B_USBE])
    begin
      state_next.ctrl[UDC_B_CPURST] = 1'b0;
    end
    // address activation is taken by hardware one cycle later
    if (state_reg.addr[UDC_B_ADDR_ACT])
    begin
      state_next.addr[UDC_B_ADDR_ACT] = 1'b0;
      state_next.addr_live = 1'b1;
    end
    // remote wakeup drives resume for a fixed time
    if (state_reg.ctrl[UDC_B_RMWAKE] && !state_reg.resume)
    begin
      state_next.resume = 1'b1;
      state_next.rsm_cnt = 16'h0000;
      state_next.flags[UDC_B_UPRSM] = 1'b1;
    end
    else if (state_reg.resume)
    begin
      if (state_reg.rsm_cnt == 16'(UDC_RESUME_CYC - 1))
      begin
        state_next.resume = 1'b0;
        state_next.ctrl[UDC_B_RMWAKE] = 1'b0;
      end
      else
      begin
        state_next.rsm_cnt = state_reg.rsm_cnt + 16'h0001;
      end
    end
    // event flags, set regardless of enables
    if (ev_end_of_resume)
    begin
      state_next.flags[UDC_B_EORSM] = 1'b1;
    end
    if (ev_line_wake && !state_reg.resume)
    begin
      state_next.flags[UDC_B_WAKE] = 1'b1;
    end
    if (susp_hit)
    begin
      state_next.flags[UDC_B_SUSP] = 1'b1;
    end
    if (ev_bus_reset_end)
    begin
      state_next.flags[UDC_B_BRST] = 1'b1;
      state_next.cpurst = state_reg.ctrl[UDC_B_CPURST];
      state_next.addr_live = 1'b0;
    end
    if (ev_sof)
    begin
      state_next.flags[UDC_B_SOF] = 1'b1;
      state_next.frame_number = sof_frame_number;
      state_next.fcrc = sof_crc_bad;
    end
    // a new setup cancels stall on its endpoint
    if (ev_setup && setup_ep != UDC_EP_FORBIDDEN)
    begin
      state_next.stall[setup_ep] = 1'b0;
    end
    // read channel
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
    if (s_axi_arvalid && state_reg.arready)
    begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rdata = {24'h000000, rd_mux(state_reg, s_axi_araddr)};
      state_next.rresp = mapped(s_axi_araddr) ? UDC_RESP_OKAY : UDC_RESP_SLVERR;
    end
    // interrupt request
    state_next.irq = |(state_next.flags & state_next.enables & UDC_FLAG_MASK);
    // pull-up choice is registered so the pins come straight from flops
    state_next.pu_dp = !state_next.usbcon[UDC_B_HOST] && !state_next.ctrl[UDC_B_DETACH]
      && !state_next.ctrl[UDC_B_LSPEED];
    state_next.pu_dm = !state_next.usbcon[UDC_B_HOST] && !state_next.ctrl[UDC_B_DETACH]
      && state_next.ctrl[UDC_B_LSPEED];
  end
  // register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.enables <= UDC_EN_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  // outputs
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign pullup_dp = state_reg.pu_dp;
  assign pullup_dm = state_reg.pu_dm;
  assign resume_drive = state_reg.resume;
  assign cpu_reset = state_reg.cpurst;
  assign dev_address = state_reg.addr[6:0];
  assign address_live = state_reg.addr_live;
  assign ep_enable = state_reg.endpoint_enable;
  assign ep_fifo_reset = state_reg.fifo_reset;
  assign ep_stall = state_reg.stall;
  assign ep_toggle_clear = state_reg.togclr;
  assign usb_irq = state_reg.irq;
  // checks
  chk_sof_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_sof |=> (state_reg.frame_number == $past(sof_frame_number) && state_reg.flags[UDC_B_SOF]))
    else $error("sof capture wrong");
  chk_crc_same: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_sof |=> state_reg.fcrc == $past(sof_crc_bad)) else $error("crc flag wrong");
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    usb_irq == |(state_reg.flags & state_reg.enables & UDC_FLAG_MASK))
    else $error("irq gating wrong");
  chk_addr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.addr[UDC_B_ADDR_ACT] |=> !state_reg.addr[UDC_B_ADDR_ACT] && address_live)
    else $error("address activate stuck");
  chk_brst_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_bus_reset_end |=> state_reg.flags[UDC_B_BRST]) else $error("reset flag missed");
  chk_cpu_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev_bus_reset_end && state_reg.ctrl[UDC_B_CPURST]) |=> cpu_reset)
    else $error("cpu reset missed");
  chk_cpurst_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !state_reg.usbcon[UDC_B_USBE] |=> !state_reg.ctrl[UDC_B_CPURST])
    else $error("cpu reset bit kept");
  chk_toggle_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    |ep_toggle_clear |=> ep_toggle_clear == 7'h00) else $error("toggle clear held");
  chk_pullup_mux: assert property (@(posedge aclk) disable iff (!aresetn)
    !(pullup_dp && pullup_dm)) else $error("both pull-ups on");
  chk_setup_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev_setup && setup_ep != UDC_EP_FORBIDDEN) |=> !ep_stall[$past(setup_ep)])
    else $error("stall not cleared");
endmodule : udc_regs

// ===== hw/udc_pkg.sv
// package for the usb device control register block
// assumes an axi4-lite slave with 32-bit data, one 25 MHz clock
package udc_pkg;
  // register byte addresses
  localparam logic [5:0] UDC_OFF_CTRL = 6'h00;
  localparam logic [5:0] UDC_OFF_FLAGS = 6'h04;
  localparam logic [5:0] UDC_OFF_ENABLES = 6'h08;
  localparam logic [5:0] UDC_OFF_ADDR = 6'h0C;
  localparam logic [5:0] UDC_OFF_FRAME_NUMBER_HI = 6'h10;
  localparam logic [5:0] UDC_OFF_FRAME_NUMBER_LO = 6'h14;
  localparam logic [5:0] UDC_OFF_FERR = 6'h18;
  localparam logic [5:0] UDC_OFF_EPSEL = 6'h1C;
  localparam logic [5:0] UDC_OFF_FIFO_RESET = 6'h20;
  localparam logic [5:0] UDC_OFF_EPCTRL = 6'h24;
  localparam logic [5:0] UDC_OFF_USBCON = 6'h28;
  // control bits
  localparam int UDC_B_DETACH = 0;
  localparam int UDC_B_RMWAKE = 1;
  localparam int UDC_B_LSPEED = 2;
  localparam int UDC_B_CPURST = 3;
  // flag and enable bits
  localparam int UDC_B_SUSP = 0;
  localparam int UDC_B_SOF = 2;
  localparam int UDC_B_BRST = 3;
  localparam int UDC_B_WAKE = 4;
  localparam int UDC_B_EORSM = 5;
  localparam int UDC_B_UPRSM = 6;
  localparam logic [7:0] UDC_FLAG_MASK = 8'h7D;
  localparam logic [7:0] UDC_EN_RESET = 8'h08;
  // address register
  localparam int UDC_B_ADDR_ACT = 7;
  // frame error bit
  localparam int UDC_B_FCRC = 4;
  // endpoint control bits
  localparam int UDC_B_ENDPOINT_ENABLE = 0;
  localparam int UDC_B_TOGRST = 3;
  localparam int UDC_B_STCLR = 4;
  localparam int UDC_B_STREQ = 5;
  localparam logic [2:0] UDC_EP_FORBIDDEN = 3'h7;
  localparam int UDC_NUM_EP = 7;
  // usb controller config register: bit 0 enable, bit 1 host mode
  localparam int UDC_B_USBE = 0;
  localparam int UDC_B_HOST = 1;
  // timing
  localparam int UDC_CLK_HZ = 25000000;
  localparam int UDC_SUSP_US = 3000;
  localparam int UDC_SUSP_CYC = UDC_SUSP_US * (UDC_CLK_HZ / 1000000);
  localparam int UDC_RESUME_US = 10;
  localparam int UDC_RESUME_CYC = UDC_RESUME_US * (UDC_CLK_HZ / 1000000);
  // axi responses
  localparam logic [1:0] UDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] UDC_RESP_SLVERR = 2'h2;
endpackage : udc_pkg

// ===== hw/udc_timer.sv
// cycle timer: counts while run is high, flags when limit reached
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module udc_timer #(
  parameter int LIMIT = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  // status
  output logic hit
);
  import udc_pkg::*;
  typedef struct packed
  {
    logic [23:0] cnt;
    logic hit;
  } udc_tmr_t;
  udc_tmr_t state_reg;
  udc_tmr_t state_next;
  // count up while run, restart when run drops
  always_comb
  begin
    state_next = state_reg;
    state_next.hit = 1'b0;
    if (!run)
    begin
      state_next.cnt = 24'h000000;
    end
    else if (state_reg.cnt == 24'(LIMIT - 1))
    begin
      state_next.hit = 1'b1;
      state_next.cnt = 24'h000000;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + 24'h000001;
    end
  end
  // register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  assign hit = state_reg.hit;
endmodule : udc_timer

// ===== test/udc_host_model.sv
// host-side usb engine model: drives bus event pulses into the register block
// assumes one clock shared with the block; every event is a one-cycle pulse
`timescale 1ns/1ps
module udc_host_model
(
  // clock
  input wire logic aclk,
  // bus events towards the block
  output logic ev_bus_reset_end,
  output logic ev_sof,
  output logic [10:0] sof_frame_number,
  output logic sof_crc_bad,
  output logic ev_end_of_resume,
  output logic ev_line_wake,
  output logic ev_setup,
  output logic [2:0] setup_ep,
  output logic bus_idle
);
  // quiet bus at time zero
  initial
  begin
    {ev_bus_reset_end, ev_sof, ev_end_of_resume, ev_line_wake, ev_setup} = 5'h00;
    sof_frame_number = 11'h000;
    sof_crc_bad = 1'b0;
    setup_ep = 3'h0;
    bus_idle = 1'b0;
  end

  // one event; k: 0 sof, 1 reset end, 2 resume end, 3 line wake, 4 setup
  task automatic fire(input int k, input logic [10:0] fn, input logic bad,
                      input logic [2:0] ep);
    ev_sof <= (k == 0);
    ev_bus_reset_end <= (k == 1);
    ev_end_of_resume <= (k == 2);
    ev_line_wake <= (k == 3);
    ev_setup <= (k == 4);
    sof_frame_number <= fn;
    sof_crc_bad <= bad;
    setup_ep <= ep;
    @(posedge aclk);
    {ev_bus_reset_end, ev_sof, ev_end_of_resume, ev_line_wake, ev_setup} <= 5'h00;
    // qualifiers go stale after the pulse: show the inverse, not the old value
    sof_frame_number <= ~fn;
    sof_crc_bad <= ~bad;
    setup_ep <= ~ep;
    @(posedge aclk);
  endtask : fire

  // bus idle level, feeds the inactivity timer
  task automatic idle(input logic v);
    bus_idle <= v;
    @(posedge aclk);
  endtask : idle
endmodule : udc_host_model

// ===== test/tb.sv
// self-checking bench for the usb device register block
// assumes the host model beside it and an axi4-lite master built from tasks
`timescale 1ns/1ps
module tb;
  import udc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ev_bus_reset_end, ev_sof, sof_crc_bad, ev_end_of_resume, ev_line_wake, ev_setup;
  logic [10:0] sof_frame_number;
  logic [2:0] setup_ep;
  logic bus_idle, pullup_dp, pullup_dm, resume_drive, cpu_reset, address_live, usb_irq;
  logic [6:0] dev_address, ep_enable, ep_fifo_reset, ep_stall, ep_toggle_clear;
  int n_errors = 0, cmp_count = 0, n_cpurst = 0, n_tog = 0, n;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [10:0] fn;
  logic [6:0] ad;

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // count one-cycle pulses that a register read cannot see
  always @(posedge aclk)
  begin
    if (cpu_reset === 1'b1) n_cpurst++;
    if (ep_toggle_clear[2] === 1'b1) n_tog++;
  end

  udc_regs u_udc_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ev_bus_reset_end(ev_bus_reset_end), .ev_sof(ev_sof),
    .sof_frame_number(sof_frame_number), .sof_crc_bad(sof_crc_bad),
    .ev_end_of_resume(ev_end_of_resume), .ev_line_wake(ev_line_wake), .ev_setup(ev_setup),
    .setup_ep(setup_ep), .bus_idle(bus_idle), .pullup_dp(pullup_dp), .pullup_dm(pullup_dm),
    .resume_drive(resume_drive), .cpu_reset(cpu_reset), .dev_address(dev_address),
    .address_live(address_live), .ep_enable(ep_enable), .ep_fifo_reset(ep_fifo_reset),
    .ep_stall(ep_stall), .ep_toggle_clear(ep_toggle_clear), .usb_irq(usb_irq));

  udc_host_model u_udc_host_model (.aclk(aclk), .ev_bus_reset_end(ev_bus_reset_end),
    .ev_sof(ev_sof), .sof_frame_number(sof_frame_number), .sof_crc_bad(sof_crc_bad),
    .ev_end_of_resume(ev_end_of_resume), .ev_line_wake(ev_line_wake), .ev_setup(ev_setup),
    .setup_ep(setup_ep), .bus_idle(bus_idle));

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // compare one value against the model
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a wait that ran out ends the run
  task automatic hang();
    n_errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  endtask : hang

  // axi write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 100) hang();
    rsp = s_axi_bresp;
    // bready stays high, and a following call drives it high again in this time step
  endtask : wr

  // axi read into rd and rsp
  task automatic rdr(input logic [5:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 100) hang();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    // rready stays high, and a following call drives it high again in this time step
  endtask : rdr

  // read and compare
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, {24'h000000, e});
  endtask : rc

  initial
  begin
    void'($urandom(32'h574F));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and an unmapped place
    rc(UDC_OFF_ENABLES, 8'h08);
    rc(UDC_OFF_FLAGS, 8'h00);
    rdr(6'h30);
    chk(rsp, UDC_RESP_SLVERR);
    // speed select, detach, refused wakeup
    wr(UDC_OFF_USBCON, 8'h01);
    wr(UDC_OFF_CTRL, 8'h02);
    chk({pullup_dp, pullup_dm, resume_drive}, 3'b100);
    rc(UDC_OFF_CTRL, 8'h00);
    wr(UDC_OFF_CTRL, 8'h04);
    chk({pullup_dp, pullup_dm}, 2'b01);
    wr(UDC_OFF_CTRL, 8'h05);
    chk({pullup_dp, pullup_dm}, 2'b00);
    wr(UDC_OFF_USBCON, 8'h03);
    wr(UDC_OFF_CTRL, 8'h04);
    chk({pullup_dp, pullup_dm}, 2'b00);
    // cpu reset on bus reset end, kept, then lost on disable
    wr(UDC_OFF_USBCON, 8'h01);
    wr(UDC_OFF_CTRL, 8'h08);
    u_udc_host_model.fire(1, 11'h000, 1'b0, 3'h0);
    rc(UDC_OFF_CTRL, 8'h08);
    chk(n_cpurst, 1);
    wr(UDC_OFF_USBCON, 8'h00);
    rc(UDC_OFF_CTRL, 8'h00);
    wr(UDC_OFF_USBCON, 8'h01);
    // flags, enables and interrupt gating
    u_udc_host_model.fire(0, 11'h000, 1'b0, 3'h0);
    u_udc_host_model.fire(2, 11'h000, 1'b0, 3'h0);
    u_udc_host_model.fire(3, 11'h000, 1'b0, 3'h0);
    chk(usb_irq, 1'b1);
    wr(UDC_OFF_FLAGS, 8'hFF);
    rc(UDC_OFF_FLAGS, 8'h3C);
    wr(UDC_OFF_ENABLES, 8'h00);
    chk(usb_irq, 1'b0);
    wr(UDC_OFF_FLAGS, 8'hF7);
    rc(UDC_OFF_FLAGS, 8'h34);
    for (n = 2; n < 6; n++)
    begin
      wr(UDC_OFF_ENABLES, 8'h01 << n);
      chk(usb_irq, (8'h34 >> n) & 1);
    end
    wr(UDC_OFF_FLAGS, 8'h00);
    rc(UDC_OFF_FLAGS, 8'h00);
    // frame number capture with and without crc error
    for (n = 0; n < 2; n++)
    begin
      fn = 11'($urandom);
      u_udc_host_model.fire(0, fn, n == 0, 3'h0);
      rc(UDC_OFF_FRAME_NUMBER_HI, {5'h00, fn[10:8]});
      rc(UDC_OFF_FRAME_NUMBER_LO, fn[7:0]);
      rc(UDC_OFF_FERR, (n == 0) ? 8'h10 : 8'h00);
    end
    // address load with self-clearing activate
    ad = 7'($urandom);
    wr(UDC_OFF_ADDR, {1'b1, ad});
    rc(UDC_OFF_ADDR, {1'b0, ad});
    chk({address_live, dev_address}, {1'b1, ad});
    // endpoint select, stall, toggle and fifo reset
    wr(UDC_OFF_EPSEL, 8'h02);
    rc(UDC_OFF_EPSEL, 8'h02);
    wr(UDC_OFF_EPCTRL, 8'h21);
    chk({ep_enable, ep_stall}, {7'h04, 7'h04});
    wr(UDC_OFF_EPCTRL, 8'h01);
    chk(ep_stall, 7'h04);
    u_udc_host_model.fire(4, 11'h000, 1'b0, 3'h2);
    chk(ep_stall, 7'h00);
    wr(UDC_OFF_EPCTRL, 8'h21);
    wr(UDC_OFF_EPCTRL, 8'h11);
    chk(ep_stall, 7'h00);
    rc(UDC_OFF_EPCTRL, 8'h01);
    wr(UDC_OFF_EPCTRL, 8'h09);
    rc(UDC_OFF_EPCTRL, 8'h01);
    chk(n_tog, 1);
    wr(UDC_OFF_FIFO_RESET, 8'h7F);
    chk(ep_fifo_reset, 7'h7F);
    wr(UDC_OFF_FIFO_RESET, 8'h00);
    chk(ep_fifo_reset, 7'h00);
    // suspend after bus inactivity, then remote wakeup
    wr(UDC_OFF_ENABLES, 8'h01);
    u_udc_host_model.idle(1'b1);
    for (n = 0; n < 80000 && usb_irq !== 1'b1; n++) @(posedge aclk);
    if (n == 80000) hang();
    chk(n > UDC_SUSP_CYC - 4 && n < UDC_SUSP_CYC + 4, 1);
    wr(UDC_OFF_CTRL, 8'h02);
    for (n = 0; n < 20 && resume_drive !== 1'b1; n++) @(posedge aclk);
    if (n == 20) hang();
    for (n = 0; n < 1000 && resume_drive === 1'b1; n++) @(posedge aclk);
    if (n == 1000) hang();
    chk(n, UDC_RESUME_CYC);
    rc(UDC_OFF_CTRL, 8'h00);
    // suspend, upstream resume, and the frame flag left from the capture loop
    rc(UDC_OFF_FLAGS, 8'h45);
    summarize();
  end
endmodule : tb
